/* File: include/adc_port_pkg.sv */
package adc_port_pkg;
  // ***********************************************
  // converter geometry
  // ***********************************************
  localparam int RESULT_BITS = 10;
  localparam int CHANNELS = 8;
  localparam int CHAN_BITS = 3;
  localparam int FRAME_BITS = 16;
  localparam int CNT_BITS = 5;
  // leading frame bits that carry the channel address
  localparam int ADDR_FIRST = 2;
  localparam int ADDR_LAST = 4;
  // result bits start here in the frame (msb first)
  localparam int DATA_FIRST = 6;
  localparam logic [CNT_BITS-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_BITS-1:0] CNT_ONE = 5'h01;
  localparam logic [CHAN_BITS-1:0] CHAN_RESET = 3'h0;
  localparam logic [RESULT_BITS-1:0] RESULT_RESET = 10'h000;
  localparam logic [RESULT_BITS-1:0] RESULT_FULL = 10'h3FF;
  localparam logic [RESULT_BITS-1:0] RESULT_ZERO = 10'h000;
endpackage

/* File: logic/adc_serial_sample_port.sv */
// Overview of operation
// - result bits change on falling edges of the serial clock.
// - control bits are captured from data input on rising serial clock edges.
// - chip select falling edge starts a new conversion cycle.
// - conversions repeat back to back while chip select stays low.
// - serial clock alone paces conversion steps and result shifting.
// - each result is a 10-bit successive-approximation value of a held sample.
// - result coding is unsigned straight binary, zero to all ones.
// - one of eight analog inputs is chosen through the control register.
module adc_serial_sample_port
  import adc_port_pkg::*;
#(
  parameter int RES = RESULT_BITS,
  parameter int NCH = CHANNELS
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic serialClk,
  input wire logic chipSelN,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic [NCH*RES-1:0] analog_inputs,
  output logic [RES-1:0] resultData,
  output logic [CHAN_BITS-1:0] resultChan,
  output logic resultValid,
  input wire logic resultReady
);
  // ***********************************************
  // pin synchronisers and edge detect
  // ***********************************************
  logic [1:0] sclkSync_r, csSync_r, dinSync_r;
  logic sclkOld_r, csOld_r;
  // serial clock resets to its idle high level so that release shows no false edge
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      sclkSync_r <= 2'h3;
      csSync_r <= 2'h3;
      dinSync_r <= 2'h0;
      sclkOld_r <= 1'b1;
      csOld_r <= 1'b1;
    end
    else
    begin
      sclkSync_r <= {sclkSync_r[0], serialClk};
      csSync_r <= {csSync_r[0], chipSelN};
      dinSync_r <= {dinSync_r[0], serialIn};
      sclkOld_r <= sclkSync_r[1];
      csOld_r <= csSync_r[1];
    end
  end
  logic sclkRise, sclkFall, csFall, csHigh;
  assign sclkRise = sclkSync_r[1] & ~sclkOld_r;
  assign sclkFall = ~sclkSync_r[1] & sclkOld_r;
  assign csFall = ~csSync_r[1] & csOld_r;
  assign csHigh = csSync_r[1];

  // ***********************************************
  // frame state
  // ***********************************************
  typedef enum logic [1:0] {IDLE = 2'h0, TRACK = 2'h1, CONVERT = 2'h3} phase_t;
  phase_t phase_r, phase_nxt;
  logic [CNT_BITS-1:0] bitCnt_r;
  // once chip select has fallen, the serial clock edges are the only thing that advances the frame
  always_comb
  begin
    phase_nxt = phase_r;
    case (phase_r)
      IDLE: if (csFall) phase_nxt = TRACK;
      TRACK: if (sclkFall && bitCnt_r == CNT_BITS'(DATA_FIRST - 1)) phase_nxt = CONVERT;
      CONVERT: if (sclkRise && bitCnt_r == CNT_ZERO) phase_nxt = TRACK;
      default: phase_nxt = IDLE;
    endcase
    if (csHigh)
      phase_nxt = IDLE;
  end
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      phase_r <= IDLE;
    else
      phase_r <= phase_nxt;
  end
  // bit counter advances on falling edges, wraps each frame
  always_ff @(posedge core_clk)
  begin
    if (!resetn || csHigh || csFall)
      bitCnt_r <= CNT_ZERO;
    else if (sclkFall)
      bitCnt_r <= (bitCnt_r == CNT_BITS'(FRAME_BITS - 1)) ? CNT_ZERO : bitCnt_r + CNT_ONE;
  end

  // ***********************************************
  // control register capture
  // ***********************************************
  logic [CHAN_BITS-1:0] chanShift_r, chan_r, convChan_r;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      chanShift_r <= CHAN_RESET;
      chan_r <= CHAN_RESET;
    end
    else if (sclkRise)
    begin
      if (bitCnt_r >= CNT_BITS'(ADDR_FIRST) && bitCnt_r <= CNT_BITS'(ADDR_LAST))
        chanShift_r <= {chanShift_r[CHAN_BITS-2:0], dinSync_r[1]};
      if (bitCnt_r == CNT_BITS'(ADDR_LAST))
        chan_r <= {chanShift_r[CHAN_BITS-2:0], dinSync_r[1]};
    end
  end

  // ***********************************************
  // sample hold and successive approximation
  // ***********************************************
  function automatic logic [RES-1:0] pick(input logic [NCH*RES-1:0] v,
    input logic [CHAN_BITS-1:0] c);
    pick = v[c*RES +: RES];
  endfunction
  logic [RES-1:0] held_r, trial_r, sar_r;
  logic [CNT_BITS-1:0] stepIdx;
  assign stepIdx = bitCnt_r - CNT_BITS'(DATA_FIRST);
  logic decBit;
  assign decBit = held_r >= (sar_r | trial_r);
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      held_r <= RESULT_RESET;
      trial_r <= RESULT_RESET;
      sar_r <= RESULT_RESET;
      convChan_r <= CHAN_RESET;
    end
    else if (phase_r == TRACK && phase_nxt == CONVERT)
    begin
      // hold the selected input, start with msb trial
      held_r <= pick(analog_inputs, chan_r);
      convChan_r <= chan_r;
      sar_r <= RESULT_ZERO;
      trial_r <= {1'b1, {(RES-1){1'b0}}};
    end
    else if (phase_r == CONVERT && sclkFall)
    begin
      // one decision per falling edge, msb first
      if (decBit)
        sar_r <= sar_r | trial_r;
      trial_r <= trial_r >> 1;
    end
  end
  assign serialOutEn = ~csHigh;
  always_ff @(posedge core_clk)
  begin
    if (!resetn || csHigh)
      serialOut <= 1'b0;
    else if (sclkFall)
      serialOut <= (phase_r == CONVERT && stepIdx < CNT_BITS'(RES)) ? decBit : 1'b0;
  end

  // ***********************************************
  // two-entry result buffer
  // ***********************************************
  logic [RES+CHAN_BITS-1:0] buf_r [2];
  logic [1:0] count_r;
  logic rdPtr_r, wrPtr_r, push, pop, done_r;
  // result completes one core clock after the falling edge that makes the lsb decision
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      done_r <= 1'b0;
    else
      done_r <= phase_r == CONVERT && sclkFall && stepIdx == CNT_BITS'(RES - 1);
  end
  assign push = done_r && count_r != 2'h2; // word lost only if host stalls two frames
  assign pop = resultValid && resultReady;
  assign resultValid = count_r != 2'h0;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      count_r <= 2'h0;
      rdPtr_r <= 1'b0;
      wrPtr_r <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_r[wrPtr_r] <= {convChan_r, sar_r};
        wrPtr_r <= ~wrPtr_r;
      end
      if (pop)
        rdPtr_r <= ~rdPtr_r;
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
  assign {resultChan, resultData} = buf_r[rdPtr_r];

  // ***********************************************
  // checks
  // ***********************************************
  tristate_release_a: assert property (@(posedge core_clk) disable iff (!resetn)
    csHigh |-> !serialOutEn ##1 !serialOut)
    else $error("output driven while deselected");
  start_on_fall_a: assert property (@(posedge core_clk) disable iff (!resetn)
    csFall |=> phase_r == TRACK) else $error("no start on select fall");
  stop_on_high_a: assert property (@(posedge core_clk) disable iff (!resetn)
    csHigh |=> phase_r == IDLE) else $error("conversion not stopped");
  out_on_fall_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!sclkFall && !csHigh && !$rose(csHigh)) |=> $stable(serialOut)) else
    $error("output moved off falling edge");
  chan_capture_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !sclkRise |=> $stable(chan_r)) else $error("channel moved off rising edge");
  result_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
    done_r |-> sar_r == held_r) else $error("result differs from held sample");
  sar_bound_a: assert property (@(posedge core_clk) disable iff (!resetn)
    phase_r == CONVERT |-> sar_r <= held_r) else $error("approximation overshoot");
endmodule

/* File: verif/host_model.sv */
module host_model
  import adc_port_pkg::*;
(
  output logic serialClk,
  output logic chipSelN,
  output logic serialIn,
  input wire logic serialOut
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [FRAME_BITS-1:0] rxWord;
  // ********
  // host side of the serial link
  // ********
  // clock idles high and stands still between frames
  initial
  begin
    serialClk = 1'b1;
    chipSelN = 1'b1;
    serialIn = 1'b0;
    rxWord = '0;
  end
  // nBits serial clocks of 160 ns; cs stays low afterwards when hold is set
  task automatic frame(input logic [CHAN_BITS-1:0] chan, input int nBits, input bit hold);
    chipSelN = 1'b0;
    #80;
    for (int k = 0; k < nBits; k++)
    begin
      // address bits msb first, the rest toggles so stale values never pass
      // address bits sit under the rises at which the device counter reads 2 to 4
      if (k >= ADDR_FIRST - 1 && k < ADDR_LAST)
        serialIn = chan[ADDR_LAST-1-k];
      else
        serialIn = ~serialIn;
      #40 serialClk = 1'b0;
      #80 serialClk = 1'b1;
      rxWord[FRAME_BITS-1-k] = serialOut;
      #40;
    end
    if (!hold)
    begin
      chipSelN = 1'b1;
      serialIn = ~serialIn;
      #400;
    end
  endtask
endmodule

/* File: verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_port_pkg::*;
  logic core_clk, resetn, serialClk, chipSelN, serialIn, serialOut, serialOutEn;
  logic resultValid, resultReady;
  logic [CHANNELS*RESULT_BITS-1:0] analog_inputs;
  logic [RESULT_BITS-1:0] resultData;
  logic [CHAN_BITS-1:0] resultChan;
  int n_errors = 0;
  int comparisons = 0;
  // ********
  // block, host and clock
  // ********
  adc_serial_sample_port adc_serial_sample_port_inst (.core_clk, .resetn, .serialClk,
    .chipSelN, .serialIn, .serialOut, .serialOutEn, .analog_inputs, .resultData,
    .resultChan, .resultValid, .resultReady);
  host_model host_model_inst (.serialClk, .chipSelN, .serialIn, .serialOut);
  // free running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // stand-in level of a channel: zero on 0, all ones on 7
  function automatic logic [RESULT_BITS-1:0] lvl(input int c);
    return (c == 7) ? RESULT_FULL : RESULT_BITS'(c * 73);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
    comparisons++;
    if (seen !== want)
    begin
      n_errors++;
      $display("[ERR] %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // bounded wait for the buffer head, compare, then pop it
  task automatic pop(input int c);
    @(posedge core_clk) #1;
    for (int i = 0; i < 50 && resultValid !== 1'b1; i++)
      @(posedge core_clk) #1;
    check(16'(resultValid), 16'h0001, "valid");
    if (resultValid !== 1'b1)
      conclude();
    else
    begin
      check(16'(resultData), 16'(lvl(c)), "data");
      check(16'(resultChan), 16'(c), "chan");
      resultReady = 1'b1;
      @(posedge core_clk) #1;
      resultReady = 1'b0;
    end
  endtask
  // every channel once, own frame each
  task automatic sweep();
    for (int c = 0; c < CHANNELS; c++)
    begin
      host_model_inst.frame(CHAN_BITS'(c), FRAME_BITS, 1'b0);
      check(host_model_inst.rxWord, 16'(lvl(c)), "serial");
      pop(c);
    end
    check({serialOutEn, serialOut}, 16'h0000, "released");
    $display("sweep done");
  endtask
  // three frames back to back with the consumer stalled: third word dropped
  task automatic burst();
    host_model_inst.frame(3'h3, FRAME_BITS, 1'b1);
    host_model_inst.frame(3'h5, FRAME_BITS, 1'b1);
    host_model_inst.frame(3'h6, FRAME_BITS, 1'b0);
    check(host_model_inst.rxWord, 16'(lvl(6)), "third");
    pop(3);
    pop(5);
    check(16'(resultValid), 16'h0000, "empty");
    $display("burst done");
  endtask
  // frame cut short by cs, then a clean frame
  task automatic abort();
    host_model_inst.frame(3'h2, 8, 1'b1);
    check(16'(serialOutEn), 16'h0001, "driving");
    host_model_inst.frame(3'h2, 0, 1'b0);
    check({serialOutEn, serialOut, resultValid}, 16'h0000, "cut");
    host_model_inst.frame(3'h4, FRAME_BITS, 1'b0);
    check(host_model_inst.rxWord, 16'(lvl(4)), "restart");
    pop(4);
    $display("abort done");
  endtask
  // main sequence
  initial
  begin
    resetn = 1'b0;
    resultReady = 1'b0;
    for (int c = 0; c < CHANNELS; c++)
      analog_inputs[c*RESULT_BITS+:RESULT_BITS] = lvl(c);
    repeat (12) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (4) @(posedge core_clk) #1;
    sweep();
    burst();
    abort();
    conclude();
  end
endmodule
